// >>> rtl/arb_if.sv
interface arb_if;
   import irq_pkg::*;
   logic [27:1] req;
   logic [27:4][1:0] lvl;
   logic found;
   src_idx_t win;

   modport client (output req, output lvl, input found, input win);
   modport arbiter (input req, input lvl, output found, output win);
endinterface

// >>> rtl/interrupt_priority_vectoring.sv
//
// Function
// R1: twenty-seven sources besides reset: two traps, watchdog, twenty-four maskable
// R2: software trap, undefined opcode trap and watchdog are non-maskable
// R3: a raised request sets the source's pending latch to one
// R4: nesting allowed; acceptance continues whenever enables permit during service
// R5: maskable request accepted only with master and own enable both one
// R6: simultaneous enabled requests accepted one at a time, highest first
// R7: programmed priority level compared first, fixed priority second
// R8: fixed order: traps together, then wake-up through serial-2 transmit
// R9: no ordering among non-maskable sources
// R10: one vector per source; both traps share the same vector
// R11: vector area select at one moves vectors to the low area
// R12: software sets vector and ram area selects to place vectors in RAM
// R13: software clears watchdog output select to get an interrupt
// R14: serial PROM mode: option code word never served as a vector
// R15: software keeps vector area select at one in serial PROM mode
// R16: non-maskable requests accepted regardless of enable flags
// R17: accepted source's pending latch cleared at acceptance
// R18: master enable saved to stack and cleared on acceptance, restored on return
// R19: reset clears pending latches, master enable and all source enables
// R20: winner's vector from the selected area presented to the core
//
// Design decisions made here: the APB slave port and the placing of the registers.
module interrupt_priority_vectoring (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [27:4] src_req,
   input wire logic software_trap_request,
   input wire logic undefined_opcode_trap,
   input wire logic watchdog_event,
   input wire logic prom_mode_pin,
   input wire logic int_accept,
   input wire logic reti,
   input wire logic reti_imf,
   output logic int_req,
   output logic [15:0] int_vector,
   output irq_pkg::src_idx_t int_source,
   output logic saved_imf,
   output logic watchdog_reset_req,
   output logic vector_area_select,
   output logic ram_area_select
);
   import irq_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   logic master_int_enable_q;
   logic [27:4] source_int_enable_q;
   logic [27:3] pending_latch_q;
   logic [2:1] trap_pending_q;
   logic [47:0] priority_level_regs_q;
   logic watchdog_output_select_q;
   logic prom_meta_q;
   logic prom_mode_q;
   logic [27:1] eligible;
   logic acc;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic wr_master;
   logic wr_enable;
   logic wr_pending;
   logic wr_level_a;
   logic wr_level_b;
   logic wr_sysctl;
   logic wr_wdctl;
   logic [27:4] maskable_ok;
   logic [3:1] nmi_ok;
   logic [15:0] vec_d;
   src_idx_t vec_idx;
   logic [31:0] rd_d;

   arb_if arb ();

   prio_arbiter u_arb (
      .a(arb.arbiter)
   );

   // ************************************************************
   // apb slave: one wait state, data and ready both registered
   // ************************************************************
   assign wr_en = psel && penable && pready && pwrite;
   assign rd_en = psel && penable && !pready && !pwrite;
   // one strobe per register keeps each register's block to its own concern
   assign wr_master = wr_en && (paddr == MASTER_OFS);
   assign wr_enable = wr_en && (paddr == ENABLE_OFS);
   assign wr_pending = wr_en && (paddr == PENDING_OFS);
   assign wr_level_a = wr_en && (paddr == LEVEL_A_OFS);
   assign wr_level_b = wr_en && (paddr == LEVEL_B_OFS);
   assign wr_sysctl = wr_en && (paddr == SYSCTL_OFS);
   assign wr_wdctl = wr_en && (paddr == WDCTL_OFS);

   // unmapped offsets answer with an error and never touch state
   always_comb begin
      case (paddr)
         MASTER_OFS, ENABLE_OFS, PENDING_OFS, LEVEL_A_OFS: addr_ok = 1'b1;
         LEVEL_B_OFS, SYSCTL_OFS, WDCTL_OFS, STATUS_OFS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= !addr_ok;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_comb begin
      rd_d = '0;
      case (paddr)
         MASTER_OFS: rd_d[IMF_BIT] = master_int_enable_q;
         ENABLE_OFS: rd_d[27:4] = source_int_enable_q;
         PENDING_OFS: rd_d[27:3] = pending_latch_q;
         LEVEL_A_OFS: rd_d = priority_level_regs_q[31:0];
         LEVEL_B_OFS: rd_d[15:0] = priority_level_regs_q[47:32];
         SYSCTL_OFS: begin
            rd_d[VAS_BIT] = vector_area_select;
            rd_d[RAS_BIT] = ram_area_select;
         end
         WDCTL_OFS: rd_d[WDSEL_BIT] = watchdog_output_select_q;
         STATUS_OFS: begin
            rd_d[ST_VEC_LSB +: 16] = int_vector;
            rd_d[ST_SRC_LSB +: 5] = int_source;
            rd_d[ST_REQ_BIT] = int_req;
            rd_d[ST_PROM_BIT] = prom_mode_q;
         end
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_en) begin
         prdata <= rd_d;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_int_enable_q <= ENABLE_RST; // R19
      end else if (wr_enable) begin
         source_int_enable_q <= pwdata[27:4];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         priority_level_regs_q <= LEVEL_RST;
      end else if (wr_level_a) begin
         priority_level_regs_q[31:0] <= pwdata;
      end else if (wr_level_b) begin
         priority_level_regs_q[47:32] <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_area_select <= VAS_RST;
         ram_area_select <= RAS_RST; // R12
      end else if (wr_sysctl) begin
         vector_area_select <= pwdata[VAS_BIT];
         ram_area_select <= pwdata[RAS_BIT];
      end
   end

   // the watchdog comes out of reset as a reset source, not an interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_output_select_q <= WDSEL_RST; // R13
      end else if (wr_wdctl) begin
         watchdog_output_select_q <= pwdata[WDSEL_BIT];
      end
   end

   // serial PROM strap comes from a pin, so it is synchronised first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prom_meta_q <= 1'b0;
         prom_mode_q <= 1'b0;
      end else begin
         prom_meta_q <= prom_mode_pin;
         prom_mode_q <= prom_meta_q;
      end
   end

   // ************************************************************
   // acceptance
   // ************************************************************
   // a request is only taken while it is offered; the stale winner of the
   // cycle after an accept is never offered because int_req drops then
   assign acc = int_accept && int_req;

   // master enable: a return has priority over software, an accept over both
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_int_enable_q <= IMF_RST; // R19
         saved_imf <= 1'b0;
      end else if (acc) begin
         saved_imf <= master_int_enable_q; // R18
         master_int_enable_q <= 1'b0; // R18
      end else if (reti) begin
         master_int_enable_q <= reti_imf; // R18
      end else if (wr_master) begin
         master_int_enable_q <= pwdata[IMF_BIT];
      end
   end

   // ************************************************************
   // pending latches
   // ************************************************************
   // a new request in the clearing cycle survives: set wins over clear.
   // software writes 0 to clear and 1 to keep; the watchdog latch is read only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_latch_q <= PENDING_RST; // R19
      end else begin
         for (int i = FIRST_MASKABLE; i <= LAST_SOURCE; i++) begin
            if (src_req[i]) begin
               pending_latch_q[i] <= 1'b1; // R3
            end else if (acc && int_source == src_idx_t'(i)) begin
               pending_latch_q[i] <= 1'b0; // R17
            end else if (wr_pending && !pwdata[i]) begin
               pending_latch_q[i] <= 1'b0;
            end
         end
         if (watchdog_event && !watchdog_output_select_q) begin
            pending_latch_q[WDT_IDX] <= 1'b1; // R3 R13
         end else if (acc && int_source == src_idx_t'(WDT_IDX)) begin
            pending_latch_q[WDT_IDX] <= 1'b0; // R17
         end
      end
   end

   // traps have no visible latch; the request is held here until taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_pending_q <= '0;
      end else begin
         if (software_trap_request) begin
            trap_pending_q[SWI_IDX] <= 1'b1;
         end else if (acc && int_source == src_idx_t'(SWI_IDX)) begin
            trap_pending_q[SWI_IDX] <= 1'b0;
         end
         if (undefined_opcode_trap) begin
            trap_pending_q[UNDEF_IDX] <= 1'b1;
         end else if (acc && int_source == src_idx_t'(UNDEF_IDX)) begin
            trap_pending_q[UNDEF_IDX] <= 1'b0;
         end
      end
   end

   // watchdog overflow turns into a reset request while the select is 1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_reset_req <= 1'b0;
      end else begin
         watchdog_reset_req <= watchdog_event && watchdog_output_select_q; // R13
      end
   end

   // ************************************************************
   // arbitration and vector
   // ************************************************************
   assign nmi_ok = {pending_latch_q[WDT_IDX], trap_pending_q}; // R2 R16
   assign maskable_ok = pending_latch_q[27:4] & source_int_enable_q &
                        {24{master_int_enable_q}}; // R5
   assign eligible = {maskable_ok, nmi_ok};
   assign arb.req = eligible; // R1
   assign arb.lvl = priority_level_regs_q;

   // both traps map onto the first slot, so the option code word below it is
   // never handed out as a vector
   assign vec_idx = (arb.win == src_idx_t'(UNDEF_IDX)) ? src_idx_t'(SWI_IDX) : arb.win; // R10 R14
   assign vec_d = (vector_area_select ? LOW_AREA_BASE : TOP_AREA_BASE) -
                  16'({vec_idx, 1'b0}); // R10 R11

   // offering continues while an earlier service runs, which gives nesting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_req <= 1'b0;
         int_vector <= RESET_VECTOR;
         int_source <= '0;
      end else if (acc) begin
         int_req <= 1'b0; // R6
      end else begin
         int_req <= arb.found; // R4
         int_vector <= vec_d; // R20
         int_source <= arb.win;
      end
   end
endmodule

// >>> rtl/irq_pkg.sv
package irq_pkg;
   // ************************************************************
   // source numbering
   // ************************************************************
   localparam int NUM_SOURCES = 27;
   localparam int SWI_IDX = 1;
   localparam int UNDEF_IDX = 2;
   localparam int WDT_IDX = 3;
   localparam int FIRST_MASKABLE = 4;
   localparam int LAST_SOURCE = 27;

   typedef logic [4:0] src_idx_t;
   typedef logic [1:0] level_t;
   typedef logic [2:0] arb_key_t;

   // ************************************************************
   // vector areas
   // ************************************************************
   localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
   localparam logic [15:0] TOP_AREA_BASE = 16'hFFFE;
   localparam logic [15:0] LOW_AREA_BASE = 16'h01FE;
   localparam logic [15:0] VECTOR_STEP = 16'h0002;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] MASTER_OFS = 8'h00;
   localparam logic [7:0] ENABLE_OFS = 8'h04;
   localparam logic [7:0] PENDING_OFS = 8'h08;
   localparam logic [7:0] LEVEL_A_OFS = 8'h0C;
   localparam logic [7:0] LEVEL_B_OFS = 8'h10;
   localparam logic [7:0] SYSCTL_OFS = 8'h14;
   localparam logic [7:0] WDCTL_OFS = 8'h18;
   localparam logic [7:0] STATUS_OFS = 8'h1C;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int IMF_BIT = 0;
   localparam int VAS_BIT = 0;
   localparam int RAS_BIT = 1;
   localparam int WDSEL_BIT = 0;
   localparam int ST_VEC_LSB = 0;
   localparam int ST_SRC_LSB = 16;
   localparam int ST_REQ_BIT = 24;
   localparam int ST_PROM_BIT = 25;
   localparam int LEVEL_A_COUNT = 16;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic IMF_RST = 1'b0;
   localparam logic [27:4] ENABLE_RST = 24'h000000;
   localparam logic [27:3] PENDING_RST = 25'h0000000;
   localparam logic [47:0] LEVEL_RST = 48'h000000000000;
   localparam logic VAS_RST = 1'b0;
   localparam logic RAS_RST = 1'b0;
   localparam logic WDSEL_RST = 1'b1;
endpackage

// >>> rtl/prio_arbiter.sv
module prio_arbiter (
   arb_if.arbiter a
);
   import irq_pkg::*;

   // key 0 is the shared non-maskable class; maskable keys are level + 1,
   // so level decides first and the lower source number breaks ties
   always_comb begin
      arb_key_t best;
      arb_key_t key;
      best = '1;
      key = '1;
      a.found = 1'b0;
      a.win = '0;
      for (int i = LAST_SOURCE; i >= SWI_IDX; i--) begin
         if (i < FIRST_MASKABLE) begin
            key = '0; // R9
         end else begin
            key = arb_key_t'({1'b0, a.lvl[i]}) + 3'h1; // R7
         end
         if (a.req[i] && (!a.found || key <= best)) begin // R6 R8
            best = key;
            a.found = 1'b1;
            a.win = src_idx_t'(i);
         end
      end
   end
endmodule

// >>> verification/core_model.sv
module core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic int_req,
   input wire logic saved_imf,
   input wire logic slow,
   output logic int_accept,
   output logic reti,
   output logic reti_imf
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // core: accept, short service, return
   // ****************************************
   logic [2:0] wait_q;
   logic [1:0] svc_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_accept <= 1'b0;
         reti <= 1'b0;
         reti_imf <= 1'b0;
         wait_q <= 3'h0;
         svc_q <= 2'h0;
      end else begin
         int_accept <= 1'b0;
         reti <= 1'b0;
         if (int_accept) begin
            svc_q <= 2'h2;
         end else if (svc_q != 2'h0) begin
            svc_q <= svc_q - 2'h1;
            // stacked master enable goes back on return, which lets further maskable accepts go on
            if (svc_q == 2'h1) begin
               reti <= 1'b1;
               reti_imf <= saved_imf;
            end
         end
         if (int_req && !int_accept && svc_q == 2'h0 && !reti) begin
            if (wait_q == (slow ? 3'h3 : 3'h0)) begin
               int_accept <= 1'b1;
               wait_q <= 3'h0;
            end else begin
               wait_q <= wait_q + 3'h1;
            end
         end
      end
   end
endmodule

// >>> verification/interrupt_priority_vectoring_checker.sv
module interrupt_priority_vectoring_checker
   import irq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic int_accept,
   input wire logic int_req,
   input wire logic vector_area_select,
   input wire logic [15:0] int_vector,
   input wire irq_pkg::src_idx_t int_source
);
   // ****************************************
   // port relations
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // traps share one slot, so index 1 and 2 map to the same word
   function automatic logic [15:0] vexp(logic v, src_idx_t s);
      return (v ? LOW_AREA_BASE : TOP_AREA_BASE) - 16'(2 * (s < 3 ? 1 : s));
   endfunction
   property p_apb_wait;
      psel && !penable |=> !pready ##1 pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("access phase not two cycles");
   property p_pready_pulse;
      pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_acc_drop;
      int_accept && int_req |=> !int_req;
   endproperty
   a_acc_drop: assert property (p_acc_drop) else $error("offer kept after accept");
   property p_stand;
      int_req && !int_accept |=> int_req;
   endproperty
   a_stand: assert property (p_stand) else $error("offer withdrawn unaccepted");
   property p_vec;
      int_req && $stable(vector_area_select) |-> int_vector == vexp(vector_area_select, int_source);
   endproperty
   a_vec: assert property (p_vec) else $error("vector does not match source");
   property p_no_opt;
      int_req |-> int_vector != 16'hFFFA;
   endproperty
   a_no_opt: assert property (p_no_opt) else $error("option word offered as vector");
   property p_src;
      int_req |-> int_source inside {[1:27]};
   endproperty
   a_src: assert property (p_src) else $error("source index out of range");
   property p_rst;
      $rose(presetn) |-> !int_req && int_vector == RESET_VECTOR;
   endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule

bind interrupt_priority_vectoring interrupt_priority_vectoring_checker checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .int_accept(int_accept), .int_req(int_req),
   .vector_area_select(vector_area_select), .int_vector(int_vector), .int_source(int_source)
);

// >>> verification/test_interrupt_priority_vectoring.sv
module test_interrupt_priority_vectoring;
   timeunit 1ns;
   timeprecision 1ps;
   import irq_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, int_req, saved_imf, wd_rst, vas, ras, int_accept, reti, reti_imf;
   logic [27:4] src_req = '0;
   logic swi = 0, undef = 0, wdt = 0, prom = 0, slow = 0;
   logic [15:0] int_vector;
   src_idx_t int_source;
   integer bad_count = 0, checks = 0, seed = 32'h70577402;
   logic [15:0] obs_v[$];
   int obs_s[$], ex[$];
   int want[28], lvl[28];
   always #4 pclk = ~pclk;
   interrupt_priority_vectoring interrupt_priority_vectoring_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
      .software_trap_request(swi), .undefined_opcode_trap(undef), .watchdog_event(wdt),
      .prom_mode_pin(prom), .int_accept(int_accept), .reti(reti), .reti_imf(reti_imf),
      .int_req(int_req), .int_vector(int_vector), .int_source(int_source),
      .saved_imf(saved_imf), .watchdog_reset_req(wd_rst), .vector_area_select(vas),
      .ram_area_select(ras));
   core_model core_model_i (.pclk(pclk), .presetn(presetn), .int_req(int_req),
      .saved_imf(saved_imf), .slow(slow), .int_accept(int_accept), .reti(reti),
      .reti_imf(reti_imf));
   // ****************************************
   // checking and bus tasks
   // ****************************************
   always @(posedge pclk) begin
      if (int_accept === 1'b1 && int_req === 1'b1) begin
         obs_s.push_back(int_source);
         obs_v.push_back(int_vector);
      end
   end
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      @(posedge pclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         bad_count++;
         stop_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1, a, d, r, e);
   endtask
   task automatic rd(string n, logic [7:0] a, logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(0, a, 32'h0, r, e);
      chk(n, exp, r & 32'h0FFFFFF8);
   endtask
   task automatic wait_acc(int n);
      int k;
      for (k = 0; k < 600 && obs_s.size() < n; k++) @(posedge pclk);
      if (obs_s.size() < n) begin
         bad_count++;
         stop_test();
      end
      repeat (6) @(posedge pclk);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [31:0] r, m, en, wa, wb, t;
      logic e, a;
      logic [15:0] base;
      int i, k, rnd, n;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      for (i = 0; i < 9; i++) begin
         apb(0, 8'(i * 4), 32'h0, r, e);
         chk("reset word", i == 6 ? 32'h1 : i == 7 ? 32'hFFFE : 32'h0, r);
         chk("slverr", 32'(i == 8), 32'(e));
      end
      wdt <= 1;
      @(posedge pclk);
      wdt <= 0;
      for (k = 0; k < 8 && wd_rst !== 1'b1; k++) @(posedge pclk);
      chk("watchdog reset", 1, 32'(wd_rst));
      repeat (4) @(posedge pclk);
      chk("watchdog offer", 0, 32'(int_req));
      wr(WDCTL_OFS, 32'h0);
      for (rnd = 0; rnd < 8; rnd++) begin
         m = $random(seed);
         en = $random(seed);
         wa = $random(seed);
         wb = $random(seed);
         t = $random(seed);
         a = t[3] | t[5];
         base = a ? LOW_AREA_BASE : TOP_AREA_BASE;
         slow <= t[4];
         prom <= t[5];
         wr(ENABLE_OFS, en);
         wr(LEVEL_A_OFS, wa);
         wr(LEVEL_B_OFS, wb);
         wr(SYSCTL_OFS, {30'h0, a, a});
         // the selects load at the edge that ends the write, so look one edge later
         @(posedge pclk);
         chk("area selects", {30'h0, a, a}, {30'h0, ras, vas});
         apb(0, STATUS_OFS, 32'h0, r, e);
         chk("prom mode", 32'(prom), 32'(r[ST_PROM_BIT]));
         obs_s.delete();
         obs_v.delete();
         src_req <= m[27:4];
         swi <= t[0];
         undef <= t[1];
         wdt <= t[2];
         @(posedge pclk);
         src_req <= '0;
         swi <= 0;
         undef <= 0;
         wdt <= 0;
         for (i = 1; i < 28; i++) begin
            want[i] = i < 4 ? t[i - 1] : m[i] & en[i];
            lvl[i] = i < 4 ? 0 : i < 20 ? wa[2 * (i - 4) +: 2] : wb[2 * (i - 20) +: 2];
         end
         wait_acc(t[0] + t[1] + t[2]);
         if (t[2:0] != 3'h0) chk("saved enable", 0, 32'(saved_imf));
         rd("pending", PENDING_OFS, {m[27:4], 4'h0});
         wr(MASTER_OFS, 32'h1);
         ex.delete();
         for (k = 0; k < 160; k++)
            for (i = 1; i < 28; i++)
               if (want[i] != 0 && k == (i < 4 ? 0 : 32 + 32 * lvl[i]) + i) ex.push_back(i);
         n = ex.size();
         wait_acc(n);
         if (n > t[0] + t[1] + t[2]) chk("saved enable", 1, 32'(saved_imf));
         chk("accepts", n, obs_s.size());
         for (k = 0; k < n && k < obs_s.size(); k++) begin
            chk("source", ex[k], obs_s[k]);
            chk("vector", 32'(base - 2 * (ex[k] < 3 ? 1 : ex[k])), obs_v[k]);
         end
         wr(MASTER_OFS, 32'h0);
         rd("left over", PENDING_OFS, {m[27:4] & ~en[27:4], 4'h0});
         wr(PENDING_OFS, 32'h0);
         rd("cleared", PENDING_OFS, 32'h0);
      end
      stop_test();
   end
endmodule
